/* File: hdl/rstseq_cfg.svh */
// Constants of the reset sequencer: timing, register offsets, field positions and codes.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef RSTSEQ_CFG_SVH
`define RSTSEQ_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ            125
`define SLOW_RC_OSCILLATOR_KHZ           32
`define RESTART_DELAY_US   16700
`define BROWNOUT_DELAY_US  50000
`define BROWNOUT_FILTER_US 100
`define ARM_LAST_TICK      2'h2

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_PIN_SEL  5'h00
`define OFF_SMOD_TWO 5'h04
`define OFF_CAUSE    5'h08
`define OFF_IRQ_STAT 5'h0C
`define OFF_IRQ_MASK 5'h10

// ****************************************
// Field codes and positions
// ****************************************
`define PIN_SEL_PORT  8'h55
`define PIN_SEL_RESET 8'hAA
`define WDT_EN_ENABLE  5'h0A
`define WDT_EN_DISABLE 5'h15
`define SM_KEEP_BIT  7
`define SM_RSVD_BIT  3
`define SM_BO_BIT    2
`define SM_FAULT_BIT 0
`define EV_EXT   0
`define EV_BO    1
`define EV_WDT   2
`define EV_WARM  3
`define EV_FAULT 4
`define EV_W     5
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: hdl/rstseq_pkg.sv */
// Types shared by the reset sequencer.
// Assumes rstseq_cfg.svh holds all numeric constants.
package rstseq_pkg;
   typedef enum logic [1:0] {ST_RUN, ST_ARM, ST_PIN, ST_DELAY} seq_state_t;
   typedef logic [1:0] axi_resp_t;
   typedef logic [4:0] reg_addr_t;
endpackage : rstseq_pkg

/* File: hdl/mcu_reset_controller.sv */
// Reset sequencer: merges power-on, pin, brownout and watchdog resets, AXI4-Lite registers.
// Assumes all inputs are synchronous to clk_sys_in; arst_n_in is the power-on reset.
// Functional notes
// - Power-on presets ports to inputs, PC zero
// - Pin release adds restart delay before running
// - Pin held low keeps operation inhibited
// - Pin low, when selected, resets to address zero
// - Pin select: 0x55 port, 0xAA reset
// - Resets restore pin select, except warm timeout
// - Supervisor active in normal and slow modes
// - Supervisor disabled in sleep and idle
// - Only filtered low supply causes brownout reset
// - Brownout reset asserts after 2~3 slow ticks
// - Brownout reset sets the brownout flag
// - Software clears brownout flag, cannot set it
// - Mode register bits 6:4 and 1 read zero
// - Brownout reset applies the long start-up delay
// - Normal timeout resets like brownout, sets timeout
// - Sleep timeout clears only PC and stack
// - Power-on clears flags; sleep timeout sets both
// - Invalid watchdog field resets, sets fault flag
`timescale 1ns/1ps
`default_nettype none
`include "rstseq_cfg.svh"

module mcu_reset_controller #(
   parameter int unsigned RESTART_CYC = `RESTART_DELAY_US * `CLK_MHZ,
   parameter int unsigned BO_CYC      = `BROWNOUT_DELAY_US * `CLK_MHZ,
   parameter int unsigned FILT_CYC    = `BROWNOUT_FILTER_US * `CLK_MHZ
) (
   // Clock and power-on reset
   input  wire logic                  clk_sys_in,
   input  wire logic                  arst_n_in,
   // AXI4-Lite write channels
   input  wire logic                  axi_awvalid_in,
   output logic                       axi_awready_out,
   input  wire rstseq_pkg::reg_addr_t axi_awaddr_in,
   input  wire logic                  axi_wvalid_in,
   output logic                       axi_wready_out,
   input  wire logic [31:0]           axi_wdata_in,
   input  wire logic [3:0]            axi_wstrb_in,
   output logic                       axi_bvalid_out,
   input  wire logic                  axi_bready_in,
   output rstseq_pkg::axi_resp_t      axi_bresp_out,
   // AXI4-Lite read channels
   input  wire logic                  axi_arvalid_in,
   output logic                       axi_arready_out,
   input  wire rstseq_pkg::reg_addr_t axi_araddr_in,
   output logic                       axi_rvalid_out,
   input  wire logic                  axi_rready_in,
   output logic [31:0]                axi_rdata_out,
   output rstseq_pkg::axi_resp_t      axi_rresp_out,
   // Reset sources and core status
   input  wire logic                  ext_reset_pin_n_in,
   input  wire logic                  low_supply_in,
   input  wire logic                  low_power_mode_in,
   input  wire logic                  wdt_timeout_in,
   input  wire logic [4:0]            wdt_enable_field_in,
   // Reset and status outputs
   output logic                       core_reset_n_out,
   output logic                       warm_reset_out,
   output logic                       supervisor_enable_out,
   output logic                       shared_pin_is_reset_out,
   output logic                       idle_clock_keep_out,
   output logic                       timeout_flag_out,
   output logic                       powerdown_flag_out,
   output logic                       irq_out
);
   import rstseq_pkg::*;

   localparam int unsigned SLOW_RC_OSCILLATOR_DIV = (`CLK_MHZ * 1000) / `SLOW_RC_OSCILLATOR_KHZ;

   logic [1:0]        rst_sync;
   logic              rst_n;
   logic [11:0]       div_cnt;
   logic              slow_rc_oscillator_tick;
   logic [13:0]       filt_cnt;
   seq_state_t        state;
   logic [22:0]       dly;
   logic [1:0]        arm_ticks;
   logic              dly_long;
   logic              hold;
   logic              hold_q;
   logic [7:0]        pin_sel;
   logic              pin_is_reset;
   logic              pin_low_req;
   logic              ext_req;
   logic              lvr_req;
   logic              wdt_req;
   logic              warm_req;
   logic              fault_req;
   logic              arm_req;
   logic              keep_bit;
   logic              rsvd_bit;
   logic              brownout_flag;
   logic              wdt_ctrl_fault_flag;
   logic              timeout_flag;
   logic              powerdown_flag;
   logic [`EV_W-1:0]  events;
   logic [`EV_W-1:0]  irq_stat;
   logic [`EV_W-1:0]  irq_mask;
   logic              wr_fire;
   logic              ar_fire;
   logic              wr_low;
   logic [31:0]       rd_word;
   logic              rd_ok;
   logic              wr_ok;

   // ****************************************
   // Reset release and slow tick
   // ****************************************
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // The slow RC clock is modelled as an enable pulse, so its phase is unknown to events.
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= 12'h000;
      end else if (slow_rc_oscillator_tick) begin
         div_cnt <= 12'h000;
      end else begin
         div_cnt <= div_cnt + 12'h001;
      end
   end
   assign slow_rc_oscillator_tick = (div_cnt == 12'(SLOW_RC_OSCILLATOR_DIV - 1));

   // ****************************************
   // Reset requests
   // ****************************************
   assign supervisor_enable_out = !low_power_mode_in;
   assign pin_is_reset = (pin_sel == `PIN_SEL_RESET);
   assign shared_pin_is_reset_out = pin_is_reset;
   assign pin_low_req = pin_is_reset && !ext_reset_pin_n_in;

   // A dip must outlast the filter window before it counts.
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         filt_cnt <= 14'h0000;
      end else if (!(low_supply_in && supervisor_enable_out) || state != ST_RUN) begin
         filt_cnt <= 14'h0000;
      end else if (filt_cnt != 14'(FILT_CYC)) begin
         filt_cnt <= filt_cnt + 14'h0001;
      end
   end

   assign ext_req   = (state == ST_RUN) && pin_low_req;
   assign lvr_req   = (state == ST_RUN) && !ext_req && low_supply_in && supervisor_enable_out
                      && (filt_cnt == 14'(FILT_CYC));
   assign fault_req = (state == ST_RUN) && !ext_req && !lvr_req
                      && wdt_enable_field_in != `WDT_EN_ENABLE
                      && wdt_enable_field_in != `WDT_EN_DISABLE;
   assign wdt_req   = (state == ST_RUN) && !ext_req && !lvr_req && !fault_req
                      && wdt_timeout_in && !low_power_mode_in;
   assign warm_req  = (state == ST_RUN) && !ext_req && !lvr_req && !fault_req
                      && wdt_timeout_in && low_power_mode_in;
   assign arm_req   = lvr_req || fault_req || wdt_req;

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         state     <= ST_DELAY;
         dly       <= 23'(RESTART_CYC - 1);
         arm_ticks <= 2'h0;
         dly_long  <= 1'b0;
      end else begin
         case (state)
            ST_RUN: begin
               if (ext_req) begin
                  state <= ST_PIN;
               end else if (arm_req) begin
                  state     <= ST_ARM;
                  arm_ticks <= 2'h0;
                  dly_long  <= lvr_req || wdt_req;
               end
            end
            ST_ARM: begin
               if (pin_low_req) begin
                  state <= ST_PIN;
               end else if (slow_rc_oscillator_tick) begin
                  arm_ticks <= arm_ticks + 2'h1;
                  if (arm_ticks == `ARM_LAST_TICK) begin
                     state <= ST_DELAY;
                     dly   <= dly_long ? 23'(BO_CYC - 1) : 23'(RESTART_CYC - 1);
                  end
               end
            end
            ST_PIN: begin
               if (ext_reset_pin_n_in) begin
                  state <= ST_DELAY;
                  dly   <= 23'(RESTART_CYC - 1);
               end
            end
            ST_DELAY: begin
               if (dly == 23'h000000) begin
                  state <= ST_RUN;
               end else begin
                  dly <= dly - 23'h000001;
               end
            end
            default: begin
               state <= ST_RUN;
            end
         endcase
      end
   end

   assign hold = (state == ST_PIN) || (state == ST_DELAY);

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         hold_q <= 1'b1;
      end else begin
         hold_q <= hold;
      end
   end

   // Low level means program counter zero and every port register preset to ones.
   // The pin term makes assertion immediate; release only ever follows the delay count.
   assign core_reset_n_out = rst_n && !hold && !pin_low_req;

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         warm_reset_out <= 1'b0;
      end else begin
         warm_reset_out <= warm_req;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   assign wr_fire = axi_awvalid_in && axi_wvalid_in && !axi_bvalid_out;
   assign wr_low  = wr_fire && axi_wstrb_in[0];
   assign ar_fire = axi_arvalid_in && !axi_rvalid_out;

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         pin_sel <= `PIN_SEL_PORT;
      end else if (hold && !hold_q) begin
         pin_sel <= `PIN_SEL_PORT;
      end else if (wr_low && axi_awaddr_in == `OFF_PIN_SEL) begin
         pin_sel <= axi_wdata_in[7:0];
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         keep_bit <= 1'b0;
         rsvd_bit <= 1'b0;
      end else if (wr_low && axi_awaddr_in == `OFF_SMOD_TWO) begin
         keep_bit <= axi_wdata_in[`SM_KEEP_BIT];
         rsvd_bit <= axi_wdata_in[`SM_RSVD_BIT];
      end
   end
   assign idle_clock_keep_out = keep_bit;

   // A set in the same cycle as a clearing write wins.
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         brownout_flag <= 1'b0;
      end else if (lvr_req) begin
         brownout_flag <= 1'b1;
      end else if (wr_low && axi_awaddr_in == `OFF_SMOD_TWO && !axi_wdata_in[`SM_BO_BIT]) begin
         brownout_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         wdt_ctrl_fault_flag <= 1'b0;
      end else if (fault_req) begin
         wdt_ctrl_fault_flag <= 1'b1;
      end else if (wr_low && axi_awaddr_in == `OFF_SMOD_TWO && !axi_wdata_in[`SM_FAULT_BIT]) begin
         wdt_ctrl_fault_flag <= 1'b0;
      end
   end

   // Only power-on clears these; software sees them read-only.
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         timeout_flag   <= 1'b0;
         powerdown_flag <= 1'b0;
      end else begin
         if (wdt_req || warm_req) begin
            timeout_flag <= 1'b1;
         end
         if (warm_req) begin
            powerdown_flag <= 1'b1;
         end
      end
   end
   assign timeout_flag_out   = timeout_flag;
   assign powerdown_flag_out = powerdown_flag;

   // ****************************************
   // Interrupts
   // ****************************************
   assign events = {fault_req, warm_req, wdt_req, lvr_req, ext_req};

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= '0;
      end else if (wr_low && axi_awaddr_in == `OFF_IRQ_STAT) begin
         irq_stat <= (irq_stat & ~axi_wdata_in[`EV_W-1:0]) | events;
      end else begin
         irq_stat <= irq_stat | events;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask <= '0;
      end else if (wr_low && axi_awaddr_in == `OFF_IRQ_MASK) begin
         irq_mask <= axi_wdata_in[`EV_W-1:0];
      end
   end
   assign irq_out = |(irq_stat & irq_mask);

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   assign axi_awready_out = wr_fire;
   assign axi_wready_out  = wr_fire;
   assign axi_arready_out = !axi_rvalid_out;
   assign wr_ok = axi_awaddr_in == `OFF_PIN_SEL || axi_awaddr_in == `OFF_SMOD_TWO
                  || axi_awaddr_in == `OFF_CAUSE || axi_awaddr_in == `OFF_IRQ_STAT
                  || axi_awaddr_in == `OFF_IRQ_MASK;

   always_comb begin
      rd_ok   = 1'b1;
      rd_word = 32'h00000000;
      case (axi_araddr_in)
         `OFF_PIN_SEL:  rd_word[7:0] = pin_sel;
         `OFF_SMOD_TWO: rd_word[7:0] = {keep_bit, 3'h0, rsvd_bit, brownout_flag,
                                        1'b0, wdt_ctrl_fault_flag};
         `OFF_CAUSE:    rd_word[3:0] = {supervisor_enable_out, hold,
                                        powerdown_flag, timeout_flag};
         `OFF_IRQ_STAT: rd_word[`EV_W-1:0] = irq_stat;
         `OFF_IRQ_MASK: rd_word[`EV_W-1:0] = irq_mask;
         default:       rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         axi_bvalid_out <= 1'b0;
         axi_bresp_out  <= `RESP_OKAY;
      end else if (wr_fire) begin
         axi_bvalid_out <= 1'b1;
         axi_bresp_out  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (axi_bready_in) begin
         axi_bvalid_out <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         axi_rvalid_out <= 1'b0;
         axi_rdata_out  <= 32'h00000000;
         axi_rresp_out  <= `RESP_OKAY;
      end else if (ar_fire) begin
         axi_rvalid_out <= 1'b1;
         axi_rdata_out  <= rd_word;
         axi_rresp_out  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (axi_rready_in) begin
         axi_rvalid_out <= 1'b0;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n);

   pin_hold_a: assert property (
      ext_req |=> state == ST_PIN && !core_reset_n_out)
      else $error("pin low did not hold reset");
   pin_release_a: assert property (
      state == ST_PIN && ext_reset_pin_n_in |=> state == ST_DELAY && dly == 23'(RESTART_CYC - 1))
      else $error("pin release did not load restart delay");
   supv_enable_a: assert property (
      low_power_mode_in |-> !supervisor_enable_out ##1 (low_power_mode_in || supervisor_enable_out))
      else $error("supervisor enable wrong for mode");
   filter_len_a: assert property (
      lvr_req |-> filt_cnt == 14'(FILT_CYC) && $past(low_supply_in))
      else $error("brownout taken before filter time");
   arm_bound_a: assert property (
      state == ST_ARM && slow_rc_oscillator_tick && arm_ticks == `ARM_LAST_TICK && !pin_low_req
      |=> !core_reset_n_out && state == ST_DELAY)
      else $error("reset not asserted after slow ticks");
   bo_set_a: assert property (
      lvr_req |=> brownout_flag && state == ST_ARM && dly_long)
      else $error("brownout flag not set");
   bo_noset_a: assert property (
      !brownout_flag && !lvr_req |=> !brownout_flag)
      else $error("brownout flag set without brownout");
   smod_zero_a: assert property (
      ar_fire && axi_araddr_in == `OFF_SMOD_TWO |=> axi_rdata_out[6:4] == 3'h0 && !axi_rdata_out[1])
      else $error("unimplemented mode bits not zero");
   bo_delay_a: assert property (
      state == ST_ARM && slow_rc_oscillator_tick && arm_ticks == `ARM_LAST_TICK && !pin_low_req && dly_long
      |=> dly == 23'(BO_CYC - 1))
      else $error("long start-up delay not loaded");
   wdt_full_a: assert property (
      wdt_req |=> timeout_flag && dly_long && state == ST_ARM)
      else $error("normal timeout not handled as brownout");
   warm_keep_a: assert property (
      warm_req |=> warm_reset_out && (core_reset_n_out || pin_low_req) && $stable(pin_sel)
                   && state == ST_RUN)
      else $error("warm timeout disturbed other state");
   warm_flags_a: assert property (
      warm_req |=> timeout_flag && powerdown_flag)
      else $error("sleep timeout flags not set");
   fault_flag_a: assert property (
      fault_req |=> wdt_ctrl_fault_flag && !dly_long && state == ST_ARM)
      else $error("watchdog field fault not recorded");
   sel_restore_a: assert property (
      hold && !hold_q |=> pin_sel == `PIN_SEL_PORT)
      else $error("pin select not restored on reset");
   sync_release_a: assert property (
      $rose(core_reset_n_out) |-> $past(state) == ST_DELAY && $past(dly) == 23'h000000)
      else $error("reset released before delay expired");

endmodule : mcu_reset_controller
`default_nettype wire

/* File: dv/reset_partner.sv */
// Partner model: external reset circuit, supply comparator and watchdog side.
// Assumes the bench calls its tasks from one process; lines change after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module reset_partner (
   // Clock
   input  wire logic       clk_in,
   // Lines into the sequencer
   output logic            pin_n_out,
   output logic            low_supply_out,
   output logic            low_power_out,
   output logic            wdt_timeout_out,
   output logic [4:0]      field_out
);
   initial begin
      pin_n_out       = 1'b1;
      low_supply_out  = 1'b0;
      low_power_out   = 1'b0;
      wdt_timeout_out = 1'b0;
      field_out       = 5'h0A;
   end
   // The pin has a pull-up, so a released pin reads high.
   task automatic pin_low(input int n);
      @(posedge clk_in);
      pin_n_out <= 1'b0;
      repeat (n) @(posedge clk_in);
      pin_n_out <= 1'b1;
   endtask : pin_low
   task automatic dip(input int n);
      @(posedge clk_in);
      low_supply_out <= 1'b1;
      repeat (n) @(posedge clk_in);
      low_supply_out <= 1'b0;
   endtask : dip
   task automatic wdt_pulse();
      @(posedge clk_in);
      wdt_timeout_out <= 1'b1;
      @(posedge clk_in);
      wdt_timeout_out <= 1'b0;
   endtask : wdt_pulse
   task automatic set(input logic lp, input logic [4:0] f);
      @(posedge clk_in);
      low_power_out <= lp;
      field_out     <= f;
   endtask : set
endmodule : reset_partner
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench of the reset sequencer, registers reached over AXI4-Lite.
// Assumes the partner model drives all reset sources but power-on; delays shortened by parameter.
`timescale 1ns/1ps
`default_nettype none
`include "rstseq_cfg.svh"
module testbench;
   import rstseq_pkg::*;
   localparam int RC = 20;
   localparam int BC = 30;
   localparam int SLOW = (`CLK_MHZ * 1000) / `SLOW_RC_OSCILLATOR_KHZ;
   logic        clk_sys_in = 1'b0;
   logic        arst_n_in = 1'b0;
   logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
   reg_addr_t   aw_a = '0, ar_a = '0;
   logic [31:0] w_d = '0, r_d;
   logic [3:0]  w_s = 4'hF;
   axi_resp_t   b_resp, r_resp;
   logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, pin_n, low_sup, low_pw, wdt_to;
   logic        core_n, warm, sup_en, pin_rst, keep, to_f, pd_f, irq;
   logic [4:0]  fld;
   int          n_fail = 0, comparisons = 0, n, m;
   always #4 clk_sys_in = ~clk_sys_in;
   reset_partner p (.clk_in(clk_sys_in), .pin_n_out(pin_n), .low_supply_out(low_sup),
      .low_power_out(low_pw), .wdt_timeout_out(wdt_to), .field_out(fld));
   mcu_reset_controller #(.RESTART_CYC(RC), .BO_CYC(BC), .FILT_CYC(5)) dut (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .axi_awvalid_in(aw_v),
      .axi_awready_out(aw_rdy), .axi_awaddr_in(aw_a), .axi_wvalid_in(w_v),
      .axi_wready_out(w_rdy), .axi_wdata_in(w_d), .axi_wstrb_in(w_s),
      .axi_bvalid_out(b_v), .axi_bready_in(b_r), .axi_bresp_out(b_resp),
      .axi_arvalid_in(ar_v), .axi_arready_out(ar_rdy), .axi_araddr_in(ar_a),
      .axi_rvalid_out(r_v), .axi_rready_in(r_r), .axi_rdata_out(r_d),
      .axi_rresp_out(r_resp), .ext_reset_pin_n_in(pin_n), .low_supply_in(low_sup),
      .low_power_mode_in(low_pw), .wdt_timeout_in(wdt_to), .wdt_enable_field_in(fld),
      .core_reset_n_out(core_n), .warm_reset_out(warm), .supervisor_enable_out(sup_en),
      .shared_pin_is_reset_out(pin_rst), .idle_clock_keep_out(keep),
      .timeout_flag_out(to_f), .powerdown_flag_out(pd_f), .irq_out(irq));
   // ****************************************
   // Compare and bus tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_rng(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask : chk_rng
   task automatic wr(input reg_addr_t a, input logic [31:0] d, input axi_resp_t e);
      @(posedge clk_sys_in);
      aw_v <= 1'b1;
      w_v  <= 1'b1;
      aw_a <= a;
      w_d  <= d;
      b_r  <= 1'b1;
      do @(negedge clk_sys_in); while (aw_rdy !== 1'b1 || w_rdy !== 1'b1);
      @(posedge clk_sys_in);
      aw_v <= 1'b0;
      w_v  <= 1'b0;
      while (b_v !== 1'b1) @(negedge clk_sys_in);
      chk(32'(b_resp), 32'(e));
      @(posedge clk_sys_in);
      b_r <= 1'b0;
   endtask : wr
   task automatic rd(input reg_addr_t a, input logic [31:0] e);
      @(posedge clk_sys_in);
      ar_v <= 1'b1;
      ar_a <= a;
      r_r  <= 1'b1;
      do @(negedge clk_sys_in); while (ar_rdy !== 1'b1);
      @(posedge clk_sys_in);
      ar_v <= 1'b0;
      do @(negedge clk_sys_in); while (r_v !== 1'b1);
      chk(r_d, e);
      chk(32'(r_resp), (a > `OFF_IRQ_MASK || a[1:0] != 2'h0) ? 32'(`RESP_SLVERR)
                                                            : 32'(`RESP_OKAY));
      @(posedge clk_sys_in);
      r_r <= 1'b0;
   endtask : rd
   // Counts falling edges until the core reset reaches the level, giving up at the limit.
   task automatic wait_core(input logic lvl, input int lim);
      n = 0;
      while (core_n !== lvl && n < lim) begin
         @(negedge clk_sys_in);
         n++;
      end
   endtask : wait_core
   task automatic give_verdict();
      if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   initial begin
      #800000;
      n_fail++;
      give_verdict();
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (2) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      chk(32'(core_n), 32'h0);
      repeat (3) @(posedge clk_sys_in);
      rd(`OFF_PIN_SEL, 32'h55);
      rd(`OFF_CAUSE, 32'h0C);
      wr(`OFF_SMOD_TWO, 32'hFF, `RESP_OKAY);
      rd(`OFF_SMOD_TWO, 32'h88);
      chk(32'(keep), 32'h1);
      wr(`OFF_SMOD_TWO, 32'h00, `RESP_OKAY);
      wr(5'h14, 32'h1, `RESP_SLVERR);
      rd(5'h14, 32'h0);
      w_s <= 4'hE;
      wr(`OFF_PIN_SEL, 32'hAA, `RESP_OKAY);
      rd(`OFF_PIN_SEL, 32'h55);
      w_s <= 4'hF;
      wait_core(1'b1, 100);
      chk(32'(core_n), 32'h1);
      wr(`OFF_PIN_SEL, 32'hAA, `RESP_OKAY);
      chk(32'(pin_rst), 32'h1);
      fork
         p.pin_low(10);
         begin
            repeat (5) @(negedge clk_sys_in);
            chk(32'(core_n), 32'h0);
         end
      join
      wait_core(1'b1, 200);
      chk_rng(n, RC, RC + 3);
      rd(`OFF_PIN_SEL, 32'h55);
      p.dip(3);
      wait_core(1'b0, 3 * SLOW + 10);
      chk_rng(n, 3 * SLOW + 10, 3 * SLOW + 10);
      rd(`OFF_SMOD_TWO, 32'h00);
      p.set(1'b1, 5'h0A);
      @(negedge clk_sys_in);
      chk(32'(sup_en), 32'h0);
      p.dip(40);
      wait_core(1'b0, 3 * SLOW + 10);
      chk_rng(n, 3 * SLOW + 10, 3 * SLOW + 10);
      p.set(1'b0, 5'h0A);
      @(negedge clk_sys_in);
      chk(32'(sup_en), 32'h1);
      p.dip(8);
      wait_core(1'b0, 4 * SLOW);
      chk_rng(n, 2 * SLOW, 3 * SLOW + 10);
      wait_core(1'b1, BC + 10);
      chk_rng(n, BC, BC + 3);
      rd(`OFF_SMOD_TWO, 32'h04);
      wr(`OFF_SMOD_TWO, 32'h00, `RESP_OKAY);
      rd(`OFF_SMOD_TWO, 32'h00);
      wr(`OFF_PIN_SEL, 32'hAA, `RESP_OKAY);
      p.wdt_pulse();
      wait_core(1'b0, 4 * SLOW);
      chk_rng(n, 2 * SLOW, 3 * SLOW + 10);
      wait_core(1'b1, BC + 10);
      chk_rng(n, BC, BC + 3);
      chk(32'(to_f), 32'h1);
      rd(`OFF_PIN_SEL, 32'h55);
      wr(`OFF_PIN_SEL, 32'hAA, `RESP_OKAY);
      p.set(1'b1, 5'h0A);
      p.wdt_pulse();
      n = 0;
      m = 0;
      repeat (6) begin
         @(negedge clk_sys_in);
         n += int'(warm === 1'b1);
         m += int'(core_n !== 1'b1);
      end
      chk_rng(n, 1, 1);
      chk_rng(m, 0, 0);
      chk(32'({to_f, pd_f}), 32'h3);
      rd(`OFF_PIN_SEL, 32'hAA);
      p.set(1'b0, 5'h1F);
      wait_core(1'b0, 4 * SLOW);
      p.set(1'b0, 5'h0A);
      chk_rng(n, 2 * SLOW, 3 * SLOW + 10);
      wait_core(1'b1, RC + 10);
      chk_rng(n, RC - 2, RC + 3);
      rd(`OFF_SMOD_TWO, 32'h01);
      rd(`OFF_IRQ_STAT, 32'h1F);
      wr(`OFF_IRQ_MASK, 32'h02, `RESP_OKAY);
      chk(32'(irq), 32'h1);
      wr(`OFF_IRQ_STAT, 32'h02, `RESP_OKAY);
      chk(32'(irq), 32'h0);
      rd(`OFF_IRQ_STAT, 32'h1D);
      arst_n_in <= 1'b0;
      @(posedge clk_sys_in);
      chk(32'({to_f, pd_f, core_n, irq}), 32'h0);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
      rd(`OFF_CAUSE, 32'h0C);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
